// File: fieldbus_listener_indicator.sv
// Passive fieldbus listener with display decoding and Wishbone configuration
// Functional notes
// - Good quality lights no status symbol
// - Uncertain quality lights the uncertain symbol
// - Bad quality shows marker and channel number
// - Bad quality keeps text, hides bar graph
// - Bar in tenths with under/over arrows
// - Rotate up to eight values, 2-20 s
// - Text sixteen characters, marquee when too long
// - Listen only, never transmit or answer
// - Eight channels remote, two with switches
// - Extract configured sources from cyclic traffic
// - Receive at the fixed fieldbus bit rate
// - Source addresses must be in valid range
// - Lock switch rejects every parameter change
// - Lock switch lights the padlock symbol
// - Lock state readable as status
// - Service port needs remote mode and unlock
// - Switch on enables, off disables
// - Remote mode ignores switches except lock
// - Accept only on off-to-on edge, unlocked
// - Address 127 clears, 126 is error
// - Value taken at byte offset 0-127
//
// Added by the designer: the register offsets and register access over Wishbone.
module fieldbus_listener_indicator
	import fli_pkg::*;
#(
	parameter int ONE_SEC_CYCLES = CLK_HZ
) (
	input wire logic CORE_CLK,          // 25 MHz clock
	input wire logic ARST_N,            // Asynchronous reset
	input wire logic BUS_RXD,           // Received fieldbus data, idle high
	input wire fli_pkg::sw_t SW,        // Configuration switches
	input wire logic WB_CYC_I,          // Wishbone cycle
	input wire logic WB_STB_I,          // Wishbone strobe
	input wire logic WB_WE_I,           // Wishbone write enable
	input wire logic [7:0] WB_ADR_I,    // Wishbone byte address
	input wire logic [3:0] WB_SEL_I,    // Wishbone byte selects
	input wire logic [31:0] WB_DAT_I,   // Wishbone write data
	output logic [31:0] WB_DAT_O,       // Wishbone read data
	output logic WB_ACK_O,              // Wishbone acknowledge
	output fli_pkg::disp_t DISP,        // Display drive
	output logic [127:0] TEXT           // Alphanumeric text, char 0 low
);
	import fli_pkg::*;

	function automatic logic [2:0] next_chan(input logic [7:0] en, input logic [2:0] cur,
			input logic [3:0] lim);
		logic [2:0] c;
		logic found;
		next_chan = cur;
		found = 1'b0;
		for (int k = 1; k <= NCHAN; k++) begin
			c = 3'(cur + 3'(k));
			if (!found && en[c] && ({1'b0, c} < lim)) begin
				next_chan = c;
				found = 1'b1;
			end
		end
	endfunction

	function automatic logic [9:0] bar_fill(input logic signed [15:0] v);
		bar_fill = '0;
		for (int k = 0; k < 10; k++) begin
			bar_fill[k] = v >= 16'(BAR_STEP * 16'(k + 1));
		end
	endfunction

	function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
			input logic [7:0] hi);
		in_range = (a >= lo) && (a <= hi) && (a[1:0] == 2'h0);
	endfunction

	// Receiver state; there is no transmit path at all, so the device stays a listener
	rx_state_t rx_state;
	logic [CNT_W-1:0] rx_cnt;
	logic [3:0] rx_bit;
	logic [7:0] rx_shift;
	logic rx_par;
	logic [5:0] idle_bits;
	logic [CNT_W-1:0] idle_cnt;
	logic in_frame;
	logic byte_stb;
	logic [7:0] rx_byte;
	logic [7:0] byte_idx;
	logic [6:0] frame_src;
	logic frame_bad;

	// Character receiver at the fieldbus rate: start, 8 data, even parity, stop
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rx_state <= RX_IDLE;
			rx_cnt <= '0;
			rx_bit <= '0;
			rx_shift <= '0;
			rx_par <= 1'b0;
			byte_stb <= 1'b0;
			rx_byte <= '0;
		end else begin
			byte_stb <= 1'b0;
			case (rx_state)
				RX_IDLE: begin
					if (!BUS_RXD) begin
						rx_state <= RX_CHAR;
						rx_cnt <= CNT_W'(CYC_PER_BIT / 2);
						rx_bit <= '0;
						rx_par <= 1'b0;
					end
				end
				RX_CHAR: begin
					if (rx_cnt != '0) begin
						rx_cnt <= rx_cnt - 1'b1;
					end else begin
						rx_cnt <= CNT_W'(CYC_PER_BIT - 1);
						rx_bit <= rx_bit + 1'b1;
						if (rx_bit == 4'h0 && BUS_RXD) begin
							rx_state <= RX_IDLE; // Glitch, not a start bit
						end else if (rx_bit >= 4'h1 && rx_bit <= 4'h8) begin
							rx_shift <= {BUS_RXD, rx_shift[7:1]};
							rx_par <= rx_par ^ BUS_RXD;
						end else if (rx_bit == 4'h9) begin
							rx_par <= rx_par ^ BUS_RXD;
						end else if (rx_bit == 4'(CHAR_BITS - 1)) begin
							rx_state <= RX_IDLE;
							byte_stb <= BUS_RXD && !rx_par;
							rx_byte <= rx_shift;
						end
					end
				end
				default: rx_state <= RX_IDLE;
			endcase
		end
	end

	// Frame delimiting by idle gap; a character error spoils the rest of the frame
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			idle_cnt <= '0;
			idle_bits <= '0;
			in_frame <= 1'b0;
			byte_idx <= '0;
			frame_src <= '0;
			frame_bad <= 1'b0;
		end else if (rx_state != RX_IDLE) begin
			idle_cnt <= '0;
			idle_bits <= '0;
			if (rx_bit == 4'(CHAR_BITS - 1) && rx_cnt == '0 && !(BUS_RXD && !rx_par)) begin
				frame_bad <= 1'b1;
			end
		end else begin
			if (byte_stb) begin
				in_frame <= 1'b1;
				byte_idx <= in_frame ? byte_idx + 1'b1 : 8'h00;
				if (!in_frame) begin
					frame_src <= rx_byte[6:0];
					frame_bad <= 1'b0;
				end
			end
			idle_cnt <= (idle_cnt == CNT_W'(CYC_PER_BIT - 1)) ? '0 : idle_cnt + 1'b1;
			if (idle_cnt == CNT_W'(CYC_PER_BIT - 1) && idle_bits != 6'(IDLE_BITS)) begin
				idle_bits <= idle_bits + 1'b1;
			end
			if (idle_bits == 6'(IDLE_BITS)) begin
				in_frame <= 1'b0;
			end
		end
	end

	// Configuration state
	chcfg_t chcfg [NCHAN];
	logic [7:0] chan_en;
	logic [4:0] ctrl_dwell;
	logic [4:0] ctrl_len;
	logic [127:0] text;
	logic cfg_err;
	logic wr_refused;
	logic set_prev;
	logic wb_req;
	logic wb_wr;
	logic cfg_allow;
	logic wb_wr_ok;
	logic dip_ok;
	logic is_chan;
	logic [2:0] wb_ch;
	logic [2:0] dip_ch;

	assign wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	assign wb_wr = wb_req && WB_WE_I;
	// Service port changes need remote mode and the lock off
	assign cfg_allow = !SW.lock && !SW.local_sel;
	assign wb_wr_ok = wb_wr && cfg_allow;
	// Switch settings only on an accept edge, in local mode, unlocked
	assign dip_ok = SW.set && !set_prev && SW.local_sel && !SW.lock;
	assign dip_ch = SW.input_channel_select ? 3'h0 : 3'h1;
	assign is_chan = in_range(WB_ADR_I, REG_CHAN_BASE, REG_CHAN_LAST);
	assign wb_ch = 3'(WB_ADR_I[5:2] - CHAN_WORD0);

	// Reset high so a switch already on at power-up is not taken as an edge
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			set_prev <= 1'b1;
		end else begin
			set_prev <= SW.set;
		end
	end

	// Channel table; only valid bus addresses enable a channel
	genvar gi;
	generate
		for (gi = 0; gi < NCHAN; gi++) begin : g_chan
			assign chan_en[gi] = chcfg[gi].addr <= ADDR_MAX;
			always_ff @(posedge CORE_CLK or negedge ARST_N) begin
				if (!ARST_N) begin
					chcfg[gi] <= '{addr: ADDR_CLEAR, offset: OFFSET_RST};
				end else if (wb_wr_ok && is_chan && wb_ch == 3'(gi)) begin
					if (WB_SEL_I[0]) begin
						chcfg[gi].addr <= WB_DAT_I[6:0];
						if (WB_DAT_I[6:0] == ADDR_CLEAR) begin
							chcfg[gi].offset <= OFFSET_RST;
						end
					end
					if (WB_SEL_I[1] && !(WB_SEL_I[0] && WB_DAT_I[6:0] == ADDR_CLEAR)) begin
						chcfg[gi].offset <= WB_DAT_I[14:8];
					end
				end else if (dip_ok && dip_ch == 3'(gi)) begin
					if (SW.addr_sel) begin
						chcfg[gi].addr <= SW.value;
						if (SW.value == ADDR_CLEAR) begin
							chcfg[gi].offset <= OFFSET_RST;
						end
					end else begin
						chcfg[gi].offset <= SW.value;
					end
				end
			end
		end
	endgenerate

	// Control word and text; byte lanes honoured
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ctrl_dwell <= DWELL_RST_S;
			ctrl_len <= '0;
			text <= '0;
		end else if (wb_wr_ok) begin
			if (WB_ADR_I == REG_CTRL && WB_SEL_I[0]) begin
				ctrl_dwell <= WB_DAT_I[4:0];
			end
			if (WB_ADR_I == REG_CTRL && WB_SEL_I[1]) begin
				// Longer text is cut at sixteen characters
				ctrl_len <= (WB_DAT_I[12:8] > TEXT_CHARS) ? TEXT_CHARS : WB_DAT_I[12:8];
			end
			if (in_range(WB_ADR_I, REG_TEXT_BASE, REG_TEXT_LAST)) begin
				for (int b = 0; b < 4; b++) begin
					if (WB_SEL_I[b]) begin
						text[WB_ADR_I[3:2] * 32 + b * 8 +: 8] <= WB_DAT_I[b * 8 +: 8];
					end
				end
			end
		end
	end

	// Sticky flags: a new event wins over a clear in the same cycle
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			cfg_err <= 1'b0;
			wr_refused <= 1'b0;
		end else begin
			if ((wb_wr_ok && is_chan && WB_SEL_I[0] && WB_DAT_I[6:0] == ADDR_INVALID)
					|| (dip_ok && SW.addr_sel && SW.value == ADDR_INVALID)) begin
				cfg_err <= 1'b1;
			end else if (wb_wr && WB_ADR_I == REG_STATUS && WB_SEL_I[0] && WB_DAT_I[2]) begin
				cfg_err <= 1'b0;
			end
			if (wb_wr && !cfg_allow && WB_ADR_I != REG_STATUS) begin
				wr_refused <= 1'b1;
			end else if (wb_wr && WB_ADR_I == REG_STATUS && WB_SEL_I[0] && WB_DAT_I[3]) begin
				wr_refused <= 1'b0;
			end
		end
	end

	// Byte strobe delayed so frame index and source have settled
	logic byte_stb_d;
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			byte_stb_d <= 1'b0;
		end else begin
			byte_stb_d <= byte_stb;
		end
	end

	// Captured values per channel
	logic [15:0] ch_val [NCHAN];
	logic [7:0] ch_q [NCHAN];
	logic [7:0] pidx;
	assign pidx = byte_idx - 8'h01;

	generate
		for (gi = 0; gi < NCHAN; gi++) begin : g_cap
			// Payload byte at offset is high value byte, then low byte, then quality
			always_ff @(posedge CORE_CLK or negedge ARST_N) begin
				if (!ARST_N) begin
					ch_val[gi] <= '0;
					ch_q[gi] <= '0;
				end else if (!chan_en[gi]) begin
					ch_q[gi] <= '0;
				end else if (byte_stb_d && in_frame && !frame_bad && byte_idx != 8'h00
						&& frame_src == chcfg[gi].addr) begin
					if (pidx == {1'b0, chcfg[gi].offset}) begin
						ch_val[gi][15:8] <= rx_byte;
					end else if (pidx == {1'b0, chcfg[gi].offset} + 8'h01) begin
						ch_val[gi][7:0] <= rx_byte;
					end else if (pidx == {1'b0, chcfg[gi].offset} + 8'h02) begin
						ch_q[gi] <= rx_byte;
					end
				end
			end
		end
	endgenerate

	// Seconds tick, dwell rotation and marquee
	logic [24:0] sec_cnt;
	logic sec_tick;
	logic [4:0] dwell_s;
	logic [4:0] dwell_cnt;
	logic [2:0] cur_ch;
	logic rot_step;
	logic [3:0] chan_lim;

	assign sec_tick = sec_cnt == 25'(ONE_SEC_CYCLES - 1);
	assign dwell_s = (ctrl_dwell < DWELL_MIN_S) ? DWELL_MIN_S :
		(ctrl_dwell > DWELL_MAX_S) ? DWELL_MAX_S : ctrl_dwell;
	assign rot_step = sec_tick && (dwell_cnt >= dwell_s - 5'h01);
	assign chan_lim = SW.local_sel ? 4'(LOCAL_NCHAN) : 4'(NCHAN);

	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			sec_cnt <= '0;
			dwell_cnt <= '0;
			cur_ch <= '0;
		end else begin
			sec_cnt <= sec_tick ? '0 : sec_cnt + 1'b1;
			if (rot_step) begin
				dwell_cnt <= '0;
				cur_ch <= next_chan(chan_en, cur_ch, chan_lim);
			end else if (sec_tick) begin
				dwell_cnt <= dwell_cnt + 1'b1;
			end
		end
	end

	// Display drive
	logic [7:0] cur_q;
	logic signed [15:0] cur_v;
	assign cur_q = ch_q[cur_ch];
	assign cur_v = ch_val[cur_ch];

	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			DISP <= '0;
		end else begin
			DISP.lock <= SW.lock;
			DISP.cfg_err <= cfg_err;
			DISP.chan <= cur_ch;
			DISP.uncertain <= (cur_q >= Q_UNCERT) && (cur_q < Q_GOOD);
			DISP.bad <= cur_q < Q_UNCERT;
			DISP.value <= (cur_q < Q_UNCERT) ? 16'h0000 : cur_v;
			// Bar hidden for bad values and in local mode
			DISP.bar_on <= (cur_q >= Q_UNCERT) && !SW.local_sel;
			DISP.bar <= bar_fill(cur_v);
			DISP.under <= cur_v < 16'sh0000;
			DISP.over <= cur_v > BAR_FULL;
			if (ctrl_len <= VISIBLE_CHARS) begin
				DISP.text_pos <= '0;
			end else if (sec_tick) begin
				DISP.text_pos <= (DISP.text_pos >= ctrl_len - 5'h01) ? '0 : DISP.text_pos + 1'b1;
			end
		end
	end
	assign TEXT = text; // Text register itself; stays while a bad value is shown

	// Wishbone answer one cycle after the request
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= '0;
		end else begin
			WB_ACK_O <= wb_req;
			if (wb_req && !WB_WE_I) begin
				WB_DAT_O <= '0;
				if (WB_ADR_I == REG_CTRL) begin
					WB_DAT_O <= {19'h0, ctrl_len, 3'h0, ctrl_dwell};
				end else if (WB_ADR_I == REG_STATUS) begin
					WB_DAT_O <= {16'h0, chan_en, 1'b0, cur_ch, wr_refused, cfg_err,
						SW.local_sel, SW.lock};
				end else if (is_chan) begin
					WB_DAT_O <= {17'h0, chcfg[wb_ch].offset, 1'b0, chcfg[wb_ch].addr};
				end else if (in_range(WB_ADR_I, REG_TEXT_BASE, REG_TEXT_LAST)) begin
					WB_DAT_O <= text[WB_ADR_I[3:2] * 32 +: 32];
				end
			end
		end
	end

	a_good_no_symbol: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
		(cur_q >= Q_GOOD) |=> !DISP.uncertain && !DISP.bad) else $error("good shows symbol");
	a_uncertain_symbol: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
		(cur_q >= Q_UNCERT && cur_q < Q_GOOD) |=> DISP.uncertain && !DISP.bad
		&& DISP.value == $past(cur_v)) else $error("uncertain not shown");
	a_bad_marker_chan: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
		(cur_q < Q_UNCERT) |=> DISP.bad && DISP.chan == $past(cur_ch)) else $error("bad marker");
	a_bad_no_bar: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
		DISP.bad |-> !DISP.bar_on) else $error("bar shown with bad value");
	a_lock_padlock: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
		SW.lock [*2] |-> DISP.lock) else $error("padlock not lit");
	a_locked_no_change: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
		SW.lock |=> $stable(ctrl_dwell) && $stable(chcfg[0]) && $stable(text))
		else $error("change while locked");
	a_set_edge_only: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
		(!dip_ok && !wb_wr_ok) |=> $stable(chcfg[1])) else $error("config without accept");
	a_local_two_chan: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
		(SW.local_sel && rot_step && cur_ch < 3'(LOCAL_NCHAN)) |=> cur_ch < 3'(LOCAL_NCHAN))
		else $error("local mode past two channels");
endmodule

// File: fieldbus_listener_indicator_tb_top.sv
// Self-checking testbench of the fieldbus listener indicator
module fieldbus_listener_indicator_tb_top
	import fli_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	typedef struct packed {
		logic we;
		logic [7:0] adr;
		logic [31:0] dat;
		logic [31:0] exp;
	} row_t;
	localparam int SEC = 20; // Shortened second keeps rotation quick
	logic core_clk, arst_n, rxd, wb_cyc, wb_stb, wb_we, wb_ack, moved;
	logic [7:0] wb_adr;
	logic [3:0] wb_sel;
	logic [31:0] wb_dat, wb_rdat, rd;
	logic [127:0] text;
	logic [2:0] cur;
	logic [2:0] got [2];
	int tch [2];
	int err_total, check_count, cyc, step;
	sw_t sw;
	disp_t disp;
	// Plain register traffic: reset values, reserved codes, unmapped read, text
	row_t rows [15] = '{
		'{1'b0, 8'h10, 32'h0, 32'h7f}, '{1'b1, 8'h10, 32'h0a, 32'h0},
		'{1'b0, 8'h10, 32'h0, 32'h0a}, '{1'b1, 8'h14, 32'h7e, 32'h0},
		'{1'b0, 8'h04, 32'h0, 32'h104}, '{1'b0, 8'h14, 32'h0, 32'h7e},
		'{1'b1, 8'h04, 32'h4, 32'h0}, '{1'b1, 8'h14, 32'h7f, 32'h0},
		'{1'b0, 8'h04, 32'h0, 32'h100}, '{1'b0, 8'h14, 32'h0, 32'h7f},
		'{1'b0, 8'h08, 32'h0, 32'h0}, '{1'b1, 8'h00, 32'h1005, 32'h0},
		'{1'b0, 8'h00, 32'h0, 32'h1005}, '{1'b1, 8'h30, 32'h44434241, 32'h0},
		'{1'b1, 8'h34, 32'h48474645, 32'h0}
	};

	fieldbus_listener_indicator #(.ONE_SEC_CYCLES(SEC)) i_fieldbus_listener_indicator (
		.CORE_CLK(core_clk), .ARST_N(arst_n), .BUS_RXD(rxd), .SW(sw),
		.WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb), .WB_WE_I(wb_we), .WB_ADR_I(wb_adr),
		.WB_SEL_I(wb_sel), .WB_DAT_I(wb_dat), .WB_DAT_O(wb_rdat), .WB_ACK_O(wb_ack),
		.DISP(disp), .TEXT(text));
	fieldbus_segment_model i_fieldbus_segment_model (.clk(core_clk), .rxd(rxd));

	// Clock and a free cycle count for dwell measurement
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	always @(posedge core_clk) cyc <= cyc + 1;

	task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] seen);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic check_bit(input string what, input logic exp, input logic seen);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %b seen %b", what, exp, seen);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// Classic single cycle; held until ack is sampled, then released for a cycle
	// Stands in for the host, whose 2400 baud serial side lies outside this block
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int n;
		@(posedge core_clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_dat <= dat;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (wb_ack !== 1'b1 && n < 20);
		if (n >= 20) err_total++;
		rd = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
	endtask

	task automatic rdchk(input string what, input logic [7:0] adr, input logic [31:0] exp);
		wb(1'b0, adr, 32'h0);
		check_val(what, exp, rd);
	endtask

	// Accept switch goes off, then on: only the rising move may be taken
	task automatic pulse_set();
		@(posedge core_clk);
		sw.set <= 1'b0;
		repeat (4) @(posedge core_clk);
		sw.set <= 1'b1;
		repeat (4) @(posedge core_clk);
	endtask

	// Watchdog sized above the seven-character frame plus its idle gap
	initial begin
		#(95000 * 40);
		err_total++;
		$display("watchdog expired");
		wrap_up();
	end

	initial begin
		arst_n = 1'b0;
		{wb_cyc, wb_stb, wb_we, wb_adr, wb_dat, cyc, moved, step, cur} = '0;
		wb_sel = 4'hf;
		sw = 12'h78e; // Local mode, set already on, address 0x0e offered
		err_total = 0;
		check_count = 0;
		repeat (5) @(posedge core_clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		check_bit("ack idle", 1'b0, wb_ack);
		check_bit("no data bad", 1'b1, disp.bad);
		check_bit("bar hidden", 1'b0, disp.bar_on);
		sw.local_sel <= 1'b0;
		sw.set <= 1'b0;
		$display("test reset done");
		foreach (rows[i]) begin
			wb(rows[i].we, rows[i].adr, rows[i].dat);
			if (!rows[i].we) check_val("row read", rows[i].exp, rd);
		end
		check_val("text low", 32'h44434241, text[31:0]);
		check_val("text next", 32'h48474645, text[63:32]);
		$display("test rows done");
		sw.lock <= 1'b1;
		wb(1'b1, 8'h10, 32'h0b);
		rdchk("locked chan", 8'h10, 32'h0a);
		rdchk("lock status", 8'h04, 32'h109);
		check_bit("padlock", 1'b1, disp.lock);
		sw.lock <= 1'b0;
		sw.local_sel <= 1'b1;
		wb(1'b1, 8'h10, 32'h0b);
		rdchk("local status", 8'h04, 32'h10a);
		sw.value <= 7'h0c;
		pulse_set();
		rdchk("switch addr", 8'h10, 32'h0c);
		sw.lock <= 1'b1;
		sw.value <= 7'h0d;
		pulse_set();
		rdchk("locked switch", 8'h10, 32'h0c);
		sw.lock <= 1'b0;
		sw.local_sel <= 1'b0;
		wb(1'b1, 8'h10, 32'h0a);
		wb(1'b1, 8'h04, 32'h0c);
		rdchk("status clear", 8'h04, 32'h100);
		$display("test lock done");
		// Two values in one frame; the offset moves to the second one mid-frame
		i_fieldbus_segment_model.send_addr(7'h0a);
		i_fieldbus_segment_model.send_value(24'h03e87f);
		check_val("value", 32'h3e8, 32'(disp.value));
		check_bit("uncertain", 1'b1, disp.uncertain);
		check_bit("not bad", 1'b0, disp.bad);
		check_val("bar", 32'h3ff, 32'(disp.bar));
		check_bit("bar on", 1'b1, disp.bar_on);
		check_bit("over", 1'b0, disp.over);
		check_bit("under", 1'b0, disp.under);
		wb(1'b1, 8'h10, 32'h030a);
		i_fieldbus_segment_model.send_value(24'h04b080);
		i_fieldbus_segment_model.end_frame();
		check_val("good value", 32'h4b0, 32'(disp.value));
		check_bit("good no symbol", 1'b0, disp.uncertain);
		check_bit("good not bad", 1'b0, disp.bad);
		check_bit("over range", 1'b1, disp.over);
		check_val("full bar", 32'h3ff, 32'(disp.bar));
		$display("test frame done");
		// Channel 2 shares the source but has no data; dwell 1 s is clamped to 2 s
		wb(1'b1, 8'h18, 32'h0a);
		wb(1'b1, 8'h00, 32'h1001);
		for (int n = 0; n < 300 && step < 2; n++) begin
			wb(1'b0, 8'h04, 32'h0);
			if (disp.text_pos !== 5'h00) moved = 1'b1;
			if (rd[6:4] !== cur) begin
				cur = rd[6:4];
				got[step] = cur;
				tch[step] = cyc;
				step++;
				if (cur === 3'h2) begin
					repeat (3) @(posedge core_clk);
					check_bit("bad shown", 1'b1, disp.bad);
					check_val("bad chan", 32'h2, 32'(disp.chan));
					check_bit("bar off", 1'b0, disp.bar_on);
				end
			end
		end
		check_val("rot first", 32'h2, 32'(got[0]));
		check_val("rot second", 32'h0, 32'(got[1]));
		check_bit("dwell", 1'b1, tch[1] - tch[0] >= 37 && tch[1] - tch[0] <= 43);
		check_bit("marquee", 1'b1, moved);
		check_val("text kept", 32'h44434241, text[31:0]);
		$display("test rotation done");
		wrap_up();
	end
endmodule

// File: fieldbus_segment_model.sv
// Fieldbus segment model: one publishing slave driving the listener's receive line
module fieldbus_segment_model
	import fli_pkg::*;
(
	input wire logic clk, // Design clock, bit times are counted in it
	output logic rxd // Receive line towards the listener, idle high
);
	timeunit 1ns;
	timeprecision 1ns;

	// Line rests high between frames, as the bus idles
	initial rxd = 1'b1;

	// One character: start, eight data bits low first, even parity, stop
	task automatic send_char(input logic [7:0] b);
		logic [10:0] f;
		f = {1'b1, ^b, b, 1'b0};
		for (int i = 0; i < 11; i++) begin
			@(posedge clk);
			rxd <= f[i];
			repeat (CYC_PER_BIT - 1) @(posedge clk);
		end
	endtask

	// Frame opening: the publishing slave's own address
	task automatic send_addr(input logic [6:0] src);
		send_char({1'b0, src});
	endtask

	// One published value: value high, value low, quality
	task automatic send_value(input logic [23:0] data);
		for (int k = 2; k >= 0; k--) begin
			send_char(data[8*k +: 8]);
		end
	endtask

	// Idle gap longer than the frame limit closes the frame
	task automatic end_frame();
		repeat ((IDLE_BITS + 1) * CYC_PER_BIT) @(posedge clk);
	endtask
endmodule

// File: fli_pkg.sv
// Shared constants and carrier types of the fieldbus listener indicator
package fli_pkg;
	// Clock and bus timing
	localparam int CLK_HZ = 25_000_000;
	localparam int BIT_RATE_BPS = 31_250;
	localparam int CYC_PER_BIT = CLK_HZ / BIT_RATE_BPS;
	localparam int CNT_W = 10;
	localparam int IDLE_BITS = 33;
	localparam int CHAR_BITS = 11;
	// Channels, dwell and text
	localparam int NCHAN = 8;
	localparam int LOCAL_NCHAN = 2;
	localparam logic [4:0] DWELL_MIN_S = 5'h02;
	localparam logic [4:0] DWELL_MAX_S = 5'h14;
	localparam logic [4:0] DWELL_RST_S = 5'h05;
	localparam logic [4:0] TEXT_CHARS = 5'h10;
	localparam logic [4:0] VISIBLE_CHARS = 5'h08;
	// Quality thresholds, address range and bar scaling
	localparam logic [7:0] Q_GOOD = 8'h80;
	localparam logic [7:0] Q_UNCERT = 8'h40;
	localparam logic [6:0] ADDR_MAX = 7'h7d;
	localparam logic [6:0] ADDR_INVALID = 7'h7e;
	localparam logic [6:0] ADDR_CLEAR = 7'h7f;
	localparam logic [6:0] OFFSET_RST = 7'h00;
	localparam logic signed [15:0] BAR_STEP = 16'sh0064;
	localparam logic signed [15:0] BAR_FULL = 16'sh03e8;
	// Register byte addresses, and the word index of the first channel register
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_CHAN_BASE = 8'h10;
	localparam logic [7:0] REG_CHAN_LAST = 8'h2c;
	localparam logic [7:0] REG_TEXT_BASE = 8'h30;
	localparam logic [7:0] REG_TEXT_LAST = 8'h3c;
	localparam logic [3:0] CHAN_WORD0 = 4'h4;

	typedef struct packed {
		logic lock;          // Write lock switch, on = locked
		logic local_sel;     // Local/remote select, on = local switches
		logic input_channel_select; // On = first channel, off = second
		logic addr_sel;      // On = value is address, off = offset
		logic set;           // Accept switch
		logic [6:0] value;   // Address or offset switches
	} sw_t;

	typedef struct packed {
		logic [6:0] addr;
		logic [6:0] offset;
	} chcfg_t;

	typedef struct packed {
		logic [15:0] value;  // Numeric field
		logic bad;           // Bad marker shown instead of value
		logic [2:0] chan;    // Channel number beside the marker
		logic uncertain;     // Uncertain symbol
		logic lock;          // Padlock symbol
		logic [9:0] bar;     // Bar segments, thermometer coded
		logic bar_on;        // Bar graph visible
		logic under;         // Below range arrow
		logic over;          // Above range arrow
		logic [4:0] text_pos; // First visible character of marquee
		logic cfg_err;       // Configuration error shown
	} disp_t;

	typedef enum logic {RX_IDLE, RX_CHAR} rx_state_t;
endpackage
